// ==== hw/capsns_autoscan.sv ====
// Purpose : Auto-scan sequencer and digital threshold comparator
// Assumes : Converter core external; one conversion result per done pulse
// Notes   : Register port is the simple SFR write strobe interface; reads follow the address
`timescale 1ns/10ps
// Contract
// - Auto-scan is on when the three start-of-conversion config bits read 111b.
// - With auto-scan on, a write to the start channel register also loads the mux select.
// - Software sets start and end, and scanning begins only on a write of 1 to busy.
// - After the set number of accumulated conversions the mux moves to the next analog pin.
// - During a scan conversion the other analog pins in the range are grounded.
// - The mux steps until the end channel, then after its conversions returns to start.
// - A conversion is attempted on the selected channel even if it is not analog.
// - A debug halt lets the sequencer finish the current rotation before stopping.
// - Auto-scan stays enabled and converting through suspend mode.
// - A greater-than comparator event on a scanned input wakes the device from suspend.
// - The threshold upper byte is a read/write register cleared at reset.
// - The threshold lower byte is a read/write register cleared at reset, compared per result.
module capsns_autoscan #(
  parameter int NCH = 32,
  parameter int CW  = 5
) (
  input  wire logic           clk_sys_i,     // System clock
  input  wire logic           rst_n_i,       // Sync reset, active low
  input  wire logic [7:0]     sfr_addr_i,    // Register address
  input  wire logic           sfr_wr_i,      // Write strobe
  input  wire logic [7:0]     sfr_wdata_i,   // Write data
  output logic      [7:0]     sfr_rdata_o,   // Read data, registered
  input  wire logic [NCH-1:0] analog_mode_i, // Pin analog configuration
  input  wire logic           debug_halt_i,  // Debugger halt
  input  wire logic           suspend_i,     // Device in suspend
  input  wire logic           conv_done_i,   // Converter result valid
  input  wire logic [15:0]    conv_result_i, // Converter result
  output logic                conv_start_o,  // Start one conversion, pulse
  output logic      [CW-1:0]  mux_sel_o,     // Input mux select
  output logic      [NCH-1:0] pin_ground_o,  // Ground these pins
  output logic                cmp_flag_o,    // Comparator flag, sticky
  output logic                wake_o         // Wake from suspend, pulse
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]          cfg_reg, thl_reg, thh_reg;
  logic [CW-1:0]       start_reg, end_reg, mux_reg;
  logic                busy_reg, cmpf_reg, start_pulse_reg, wake_reg;
  logic [NCH-1:0]      gnd_reg;
  logic [7:0]          rdata_reg;
  logic [1:0]          acc_cnt_reg;
  capsns_pkg::capsns_state_t state_reg, state_next;

  // ****************************************
  // Decode
  // ****************************************
  wire logic         wr_cfg   = sfr_wr_i && (sfr_addr_i == capsns_pkg::ADDR_CFG);
  wire logic         wr_ctrl  = sfr_wr_i && (sfr_addr_i == capsns_pkg::ADDR_CTRL);
  wire logic         wr_start = sfr_wr_i && (sfr_addr_i == capsns_pkg::ADDR_START);
  wire logic         wr_end   = sfr_wr_i && (sfr_addr_i == capsns_pkg::ADDR_END);
  wire logic         wr_mux   = sfr_wr_i && (sfr_addr_i == capsns_pkg::ADDR_MUX);
  wire logic         wr_thl   = sfr_wr_i && (sfr_addr_i == capsns_pkg::ADDR_THL);
  wire logic         wr_thh   = sfr_wr_i && (sfr_addr_i == capsns_pkg::ADDR_THH);
  wire logic         scan_en  = cfg_reg[capsns_pkg::CFG_SOC_LSB +: 3] == capsns_pkg::SOC_AUTOSCAN;
  wire logic [1:0]   acc_sel  = cfg_reg[1:0];
  // Conversions per channel are field plus one; the counter wraps at the field value
  wire logic [1:0]   acc_last = acc_sel;
  // scanning starts only on busy write
  wire logic         go       = wr_ctrl && sfr_wdata_i[capsns_pkg::CTRL_BUSY] && scan_en;
  wire logic [15:0]  thresh   = {thh_reg, thl_reg};
  wire logic         gt_event = conv_done_i && (state_reg == capsns_pkg::CAPSNS_CONV)
                                && (conv_result_i > thresh);
  wire logic         chan_last = acc_cnt_reg == acc_last;
  wire logic         at_end   = mux_reg == end_reg;
  wire logic [CW-1:0] next_chan;
  wire logic         clr_cmpf = wr_ctrl && !sfr_wdata_i[capsns_pkg::CTRL_CMPF];

  capsns_chan_pick #(.NCH(NCH), .CW(CW)) u_pick (
    .cur_i    (mux_reg),
    .start_i  (start_reg),
    .end_i    (end_reg),
    .analog_i (analog_mode_i),
    .next_o   (next_chan)
  );

  // ground other analog pins in range
  logic [NCH-1:0] gnd_next;
  always_comb begin
    gnd_next = '0;
    for (int i = 0; i < NCH; i++) begin
      if ((i >= int'(start_reg)) && (i <= int'(end_reg)) && (i != int'(mux_reg))) begin
        gnd_next[i] = analog_mode_i[i] && (state_reg != capsns_pkg::CAPSNS_IDLE);
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      capsns_pkg::CAPSNS_IDLE: begin
        if (go) begin
          state_next = capsns_pkg::CAPSNS_CONV;
        end
      end
      capsns_pkg::CAPSNS_CONV: begin
        if (conv_done_i && chan_last) begin
          state_next = capsns_pkg::CAPSNS_STEP;
        end
      end
      default: begin
        // suspend does not stop the scan
        if (!scan_en || (debug_halt_i && at_end)) begin
          state_next = capsns_pkg::CAPSNS_IDLE;
        end else begin
          state_next = capsns_pkg::CAPSNS_CONV;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg   <= capsns_pkg::CAPSNS_IDLE;
      acc_cnt_reg <= 2'h0;
      mux_reg     <= capsns_pkg::RST_CHAN;
    end else begin
      state_reg <= state_next;
      if (state_reg == capsns_pkg::CAPSNS_CONV && conv_done_i) begin
        acc_cnt_reg <= chan_last ? 2'h0 : acc_cnt_reg + 2'h1;
      end
      if (state_reg == capsns_pkg::CAPSNS_STEP && state_next == capsns_pkg::CAPSNS_CONV) begin
        // next channel converted even if not analog
        mux_reg <= next_chan;
      end else if (wr_start && scan_en) begin
        mux_reg <= sfr_wdata_i[CW-1:0];
      end else if (wr_mux) begin
        mux_reg <= sfr_wdata_i[CW-1:0];
      end
    end
  end

  // ****************************************
  // Register file and outputs
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_reg   <= capsns_pkg::RST_BYTE;
      start_reg <= capsns_pkg::RST_CHAN;
      end_reg   <= capsns_pkg::RST_CHAN;
      thl_reg   <= capsns_pkg::RST_BYTE;
      thh_reg   <= capsns_pkg::RST_BYTE;
    end else begin
      if (wr_cfg) cfg_reg <= sfr_wdata_i;
      if (wr_start) start_reg <= sfr_wdata_i[CW-1:0];
      if (wr_end) end_reg <= sfr_wdata_i[CW-1:0];
      if (wr_thl) thl_reg <= sfr_wdata_i;
      if (wr_thh) thh_reg <= sfr_wdata_i;
    end
  end

  wire logic [7:0] rd_mux =
    (sfr_addr_i == capsns_pkg::ADDR_CFG)   ? cfg_reg :
    (sfr_addr_i == capsns_pkg::ADDR_CTRL)  ? {busy_reg, 6'h00, cmpf_reg} :
    (sfr_addr_i == capsns_pkg::ADDR_START) ? 8'(start_reg) :
    (sfr_addr_i == capsns_pkg::ADDR_END)   ? 8'(end_reg) :
    (sfr_addr_i == capsns_pkg::ADDR_MUX)   ? 8'(mux_reg) :
    (sfr_addr_i == capsns_pkg::ADDR_THL)   ? thl_reg :
    (sfr_addr_i == capsns_pkg::ADDR_THH)   ? thh_reg : 8'h00;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      busy_reg        <= 1'b0;
      cmpf_reg        <= 1'b0;
      start_pulse_reg <= 1'b0;
      wake_reg        <= 1'b0;
      gnd_reg         <= '0;
      rdata_reg       <= 8'h00;
    end else begin
      busy_reg <= state_next != capsns_pkg::CAPSNS_IDLE;
      cmpf_reg <= gt_event | (cmpf_reg & ~clr_cmpf);
      start_pulse_reg <= (state_next == capsns_pkg::CAPSNS_CONV) &&
                         ((state_reg != capsns_pkg::CAPSNS_CONV) || conv_done_i);
      wake_reg  <= gt_event && suspend_i;
      gnd_reg   <= gnd_next;
      rdata_reg <= rd_mux;
    end
  end

  assign sfr_rdata_o  = rdata_reg;
  assign conv_start_o = start_pulse_reg;
  assign mux_sel_o    = mux_reg;
  assign pin_ground_o = gnd_reg;
  assign cmp_flag_o   = cmpf_reg;
  assign wake_o       = wake_reg;

  // ****************************************
  // Assertions
  // ****************************************
  a_busy_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_reg == capsns_pkg::CAPSNS_IDLE && !go) |=> !busy_reg)
    else $error("busy set without start write");
  a_enable_pattern: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (go) |-> cfg_reg[6:4] == 3'h7)
    else $error("scan started without enable pattern");
  a_mux_copy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_start && scan_en && state_reg != capsns_pkg::CAPSNS_STEP) |=>
      mux_sel_o == $past(sfr_wdata_i[CW-1:0]))
    else $error("start write not copied to mux");
  a_step_next: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_reg == capsns_pkg::CAPSNS_CONV && conv_done_i && chan_last) |=>
      state_reg == capsns_pkg::CAPSNS_STEP)
    else $error("no step after last conversion");
  a_wrap_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_reg == capsns_pkg::CAPSNS_STEP && at_end && scan_en && !debug_halt_i) |=>
      mux_sel_o == $past(start_reg))
    else $error("no wrap to start");
  a_ground_self: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_reg == capsns_pkg::CAPSNS_CONV) |-> ##1 !pin_ground_o[$past(mux_reg)])
    else $error("converted pin grounded");
  a_halt_rotation: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_reg == capsns_pkg::CAPSNS_STEP && scan_en && !at_end) |=>
      state_reg == capsns_pkg::CAPSNS_CONV)
    else $error("stopped mid rotation");
  a_cmp_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    gt_event |=> cmp_flag_o)
    else $error("comparator flag missed");
  a_wake_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (gt_event && suspend_i) |=> wake_o)
    else $error("no wake on compare");
  a_thresh_reset: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> (thh_reg == 8'h00 && thl_reg == 8'h00))
    else $error("threshold not cleared");
  c_scan_go:   cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) go);
  c_wrap:      cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_reg == capsns_pkg::CAPSNS_STEP && at_end);
  c_wake:      cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) wake_o);
endmodule

// ==== hw/capsns_pkg.sv ====
// Purpose : Constants for the capacitive sense auto-scan sequencer
// Assumes : 8-bit special-function register port, addresses as printed
// Notes   : Config, start, end and mux addresses are local choices
package capsns_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_CFG     = 8'h9E;
  localparam logic [7:0] ADDR_CTRL    = 8'hB0;
  localparam logic [7:0] ADDR_START   = 8'hDD;
  localparam logic [7:0] ADDR_END     = 8'hDE;
  localparam logic [7:0] ADDR_MUX     = 8'h9C;
  localparam logic [7:0] ADDR_THL     = 8'hFD;
  localparam logic [7:0] ADDR_THH     = 8'hFE;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int         CFG_SOC_LSB  = 4;
  localparam logic [2:0] SOC_AUTOSCAN = 3'h7;
  localparam int         CTRL_BUSY    = 7;
  localparam int         CTRL_CMPF    = 0;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [4:0] RST_CHAN     = 5'h00;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    CAPSNS_IDLE = 2'b00,
    CAPSNS_CONV = 2'b01,
    CAPSNS_STEP = 2'b11
  } capsns_state_t;
endpackage

// ==== hw/capsns_chan_pick.sv ====
// Purpose : Finds next analog-input channel after the current one
// Assumes : Channel numbers below 2**CW
// Notes   : Wraps to start when end is reached or passed
`timescale 1ns/10ps
module capsns_chan_pick #(
  parameter int NCH = 32,
  parameter int CW  = 5
) (
  input  wire logic [CW-1:0]  cur_i,    // Current channel
  input  wire logic [CW-1:0]  start_i,  // Range start
  input  wire logic [CW-1:0]  end_i,    // Range end
  input  wire logic [NCH-1:0] analog_i, // Analog-mode pins
  output logic      [CW-1:0]  next_o    // Next channel
);
  always_comb begin
    logic found;
    found  = 1'b0;
    next_o = start_i;
    if (cur_i < end_i) begin
      for (int i = 1; i < NCH; i++) begin
        if (!found && (int'(cur_i) + i <= int'(end_i)) && analog_i[int'(cur_i) + i]) begin
          found  = 1'b1;
          next_o = CW'(int'(cur_i) + i);
        end
      end
      // No analog pin left before end: land on end itself, converted anyway
      if (!found) begin
        next_o = end_i;
      end
    end
  end
endmodule

// ==== dv/capsns_sense_model.sv ====
// Purpose : Behavioural capacitive converter facing the auto-scan block
// Assumes : One conversion in flight at a time; latency set by the bench
// Notes   : Result lines carry inverted junk outside the done cycle
`timescale 1ns/10ps
module capsns_sense_model (
  input  wire logic        clk_sys_i, // System clock
  input  wire logic        rst_n_i,   // Sync reset, active low
  input  wire logic        start_i,   // Conversion request
  input  wire logic [3:0]  lat_i,     // Cycles to result, 2 or more
  input  wire logic [15:0] value_i,   // Value to report
  output logic             done_o,    // Result valid, pulse
  output logic      [15:0] result_o   // Conversion result
);
  // ****************************************
  // Conversion timer
  // ****************************************
  logic [3:0] wait_reg;
  // Junk between results so a stale value never passes for a fresh one
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wait_reg <= 4'h0;
      done_o   <= 1'b0;
      result_o <= 16'h0;
    end else begin
      done_o   <= (wait_reg == 4'h1);
      result_o <= (wait_reg == 4'h1) ? value_i : ~result_o;
      if (start_i) wait_reg <= lat_i;
      else if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule

// ==== dv/capacitive_sense_autoscan_bench.sv ====
// Purpose : Self-checking bench for the auto-scan sequencer
// Assumes : Seeded random ranges, thresholds, results and latencies
// Notes   : Each run ends with a debug halt that must close the rotation
`timescale 1ns/10ps
module capacitive_sense_autoscan_bench;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0;
  logic        debug_halt_i = 1'b0, suspend_i = 1'b0;
  logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [31:0] analog_mode_i = 32'h0, pin_ground_o;
  logic        conv_done_i, conv_start_o, cmp_flag_o, wake_o, exp_flag;
  logic [15:0] conv_result_i, res = 16'h0, th = 16'h0;
  logic [4:0]  mux_sel_o, s = 5'h00, e = 5'h00, ch;
  logic [3:0]  lat = 4'h2;
  logic [1:0]  acc, cnt;
  int          err_count = 0, checked = 0, seed = 77, cyc = 0;
  int          nstart = 0, nwake = 0, xwake = 0, i;
  always #2 clk_sys_i = ~clk_sys_i;
  capsns_autoscan #(.NCH(32), .CW(5)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .analog_mode_i(analog_mode_i), .debug_halt_i(debug_halt_i),
    .suspend_i(suspend_i), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .conv_start_o(conv_start_o), .mux_sel_o(mux_sel_o), .pin_ground_o(pin_ground_o),
    .cmp_flag_o(cmp_flag_o), .wake_o(wake_o));
  capsns_sense_model u_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .start_i(conv_start_o), .lat_i(lat), .value_i(res), .done_o(conv_done_i),
    .result_o(conv_result_i));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Smallest analog channel above c up to the end, the end itself, else wrap
  function automatic logic [4:0] nxt(input logic [4:0] c);
    nxt = s;
    for (int k = 31; k > 0; k--)
      if (k > c && k <= e && (analog_mode_i[k] || k == e)) nxt = 5'(k);
  endfunction
  function automatic logic [31:0] gnd(input logic [4:0] c);
    gnd = 32'h0;
    for (int k = 0; k < 32; k++)
      if (k >= s && k <= e && k != c) gnd[k] = analog_mode_i[k];
  endfunction
  // ****************************************
  // Bus tasks, rchk compares under one fixed rdata tag
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    sfr_wr_i    <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    sfr_addr_i <= a;
    @(posedge clk_sys_i);
    #1;
    chk("rdata", sfr_rdata_o, exp);
  endtask
  task automatic rst();
    @(posedge clk_sys_i);
    rst_n_i      <= 1'b0;
    debug_halt_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    ch = s;
    cnt = 2'h0;
    exp_flag = 1'b0;
    nstart = 0;
    nwake = 0;
    xwake = 0;
  endtask
  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(posedge clk_sys_i) begin
    cyc++;
    res <= ($random(seed) & 1) ? th : 16'($random(seed));
    if (cyc > 20000) begin
      err_count++;
      end_of_test();
    end
    if (conv_start_o) nstart++;
    if (wake_o) nwake++;
    if (rst_n_i && conv_done_i) begin
      chk("mux_sel", mux_sel_o, ch);
      chk("pin_ground", pin_ground_o, gnd(ch));
      chk("cmp_flag", cmp_flag_o, exp_flag);
      if (conv_result_i > th) begin
        exp_flag = 1'b1;
        if (suspend_i) xwake++;
      end
      if (cnt == acc) begin
        ch = nxt(ch);
        cnt = 2'h0;
      end else cnt++;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst();
    rchk(8'h01, 8'h00);
    for (i = 0; i < 7; i++) begin
      wr(capsns_pkg::ADDR_CFG, {1'b0, 3'(i), 4'h0});
      wr(capsns_pkg::ADDR_CTRL, 8'h80);
      repeat (4) @(posedge clk_sys_i);
      chk("starts", nstart, 0);
      rchk(capsns_pkg::ADDR_CTRL, 8'h00);
      wr(capsns_pkg::ADDR_MUX, 8'(i + 3));
      wr(capsns_pkg::ADDR_START, 8'h1F);
      #1;
      chk("mux_hold", mux_sel_o, i + 3);
    end
    for (int r = 0; r < 6; r++) begin
      s = (r == 1) ? 5'h1B : 5'($random(seed)) % 5'h1C;
      e = (r == 0) ? s : s + 5'h01 + 5'($random(seed) & 3);
      acc = 2'($random(seed));
      lat = 4'h2 + 4'($random(seed) & 7);
      th = 16'($random(seed));
      analog_mode_i <= $random(seed);
      suspend_i <= r[0];
      rst();
      rchk(capsns_pkg::ADDR_THL, 8'h00);
      rchk(capsns_pkg::ADDR_THH, 8'h00);
      wr(capsns_pkg::ADDR_THL, th[7:0]);
      wr(capsns_pkg::ADDR_THH, th[15:8]);
      rchk(capsns_pkg::ADDR_THL, th[7:0]);
      rchk(capsns_pkg::ADDR_THH, th[15:8]);
      wr(capsns_pkg::ADDR_CFG, {1'b0, capsns_pkg::SOC_AUTOSCAN, 2'h0, acc});
      wr(capsns_pkg::ADDR_START, {3'h0, s});
      #1;
      chk("mux_copy", mux_sel_o, s);
      wr(capsns_pkg::ADDR_END, {3'h0, e});
      wr(capsns_pkg::ADDR_CTRL, 8'h80);
      for (i = 0; i < 600 && nstart < 12; i++) @(posedge clk_sys_i);
      chk("scanning", 32'(nstart >= 12), 1);
      debug_halt_i <= 1'b1;
      repeat (250) @(posedge clk_sys_i);
      i = nstart;
      repeat (30) @(posedge clk_sys_i);
      chk("halt_starts", nstart, i);
      chk("halt_chan", {cnt, ch}, {2'h0, s});
      chk("wakes", nwake, xwake);
      chk("flag_end", cmp_flag_o, exp_flag);
      rchk(capsns_pkg::ADDR_CTRL, {7'h00, exp_flag});
    end
    end_of_test();
  end
endmodule
